// ==== core/pch_config_regs.sv ====
`timescale 1ns/100ps
// Overview of operation
// - Tenure limit counts PCI clocks that bound bus ownership as initiator.
// - Tenure counter restarts from zero when the initiator asserts FRAME#.
// - On expiry, transaction ends once the arbiter removes GNT#.
// - Line size setting drives line-oriented read and invalidate-write commands.
// - Self-test byte always reads zero: no built-in self-test.
// - Header layout byte always reads zero: standard single-function header.
// - Window base pointer, bits 31:12, is read-write.
// - Writing all ones then reading returns FFFF F000h: 4 Kbyte window.
// - Window size field, bits 11:4, is read-only zero.
// - Prefetchable flag reads zero: window is not prefetchable.
// - Locator type reads zero: 32-bit base anywhere in memory space.
// - Space indicator reads zero: window decodes in memory space.
// - Board and vendor identifiers load from serial memory; software cannot write.
// - Capability pointer is read-only and returns 44h.
// - Power management capability occupies configuration words at 44h and 48h.
module pch_config_regs #(
  parameter logic [31:0] PM_CAP_WORD = 32'h0000_0001 // Arbitrary fixed capability word
) (
  input wire logic clk,
  input wire logic nrst,
  input wire pch_pkg::pch_cfg_req_type cfg_req,
  output pch_pkg::pch_cfg_rsp_type cfg_rsp,
  input wire pch_pkg::pch_init_type init_status,
  output logic [7:0] line_size_setting,
  output logic [31:0] window_base_address,
  output logic [1:0] power_state,
  output logic tenure_expired,
  output logic tenure_end_request,
  input wire logic ee_sdi,
  output logic ee_sclk,
  output logic ee_cs,
  output logic board_id_loaded
);

  typedef struct packed {
    pch_pkg::pch_cfg_rsp_type rsp;
    logic [15:0] tenure_line;
    logic [31:0] base;
    logic [31:0] pm_ctrl;
  } pch_regs_type;

  pch_regs_type s_reg;
  pch_regs_type s_next;
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n_sync;
  logic [31:0] byte_mask;
  logic [31:0] board_word;
  logic [31:0] read_word;
  logic hit_tenure;
  logic hit_base;
  logic hit_board;
  logic hit_cap;
  logic hit_pm_first;
  logic hit_pm_second;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  // Assertion is asynchronous, release is aligned to clk to avoid removal races
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n_sync = rst_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Byte lane mask from the byte enables
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign byte_mask[8*lane +: 8] = {8{cfg_req.be[lane]}};
    end
  endgenerate

  // Merge only enabled lanes of writable bits; fixed bits keep their value
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_value,
    input logic [31:0] new_value,
    input logic [31:0] lanes,
    input logic [31:0] rw_mask
  );
    logic [31:0] keep;
    keep = lanes & rw_mask;
    return (old_value & ~keep) | (new_value & keep);
  endfunction : merge_write

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // The header byte pair shares the dword of the tenure register
  assign hit_tenure = (cfg_req.dw_addr == pch_pkg::OFS_TENURE[7:2]);
  assign hit_base = (cfg_req.dw_addr == pch_pkg::OFS_BASE[7:2]);
  assign hit_board = (cfg_req.dw_addr == pch_pkg::OFS_BOARD_ID[7:2]);
  assign hit_cap = (cfg_req.dw_addr == pch_pkg::OFS_CAP_PTR[7:2]);
  assign hit_pm_first = (cfg_req.dw_addr == pch_pkg::OFS_PM_FIRST[7:2]);
  assign hit_pm_second = (cfg_req.dw_addr == pch_pkg::OFS_PM_SECOND[7:2]);

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection
  always_comb begin
    read_word = 32'h0000_0000;
    if (hit_tenure) begin
      read_word[15:0] = s_reg.tenure_line;
      read_word[pch_pkg::HEADER_LANE_LSB +: 8] = pch_pkg::HEADER_LAYOUT_VALUE;
      read_word[pch_pkg::HEADER_LANE_LSB + 8 +: 8] = pch_pkg::SELF_TEST_VALUE;
    end else if (hit_base) begin
      // Low twelve bits never store anything, so all-ones reads as FFFF F000h
      read_word = s_reg.base & pch_pkg::BASE_RW_MASK;
    end else if (hit_board) begin
      // A half-shifted word must never be seen, so hold zero until the load ends
      read_word = board_id_loaded ? board_word : 32'h0000_0000;
    end else if (hit_cap) begin
      read_word[7:0] = pch_pkg::CAP_PTR_VALUE;
    end else if (hit_pm_first) begin
      read_word = PM_CAP_WORD;
    end else if (hit_pm_second) begin
      read_word = s_reg.pm_ctrl & pch_pkg::PM_CTRL_RW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register update and answer
  // Every access is answered one cycle later; unmapped offsets read zero
  always_comb begin
    s_next = s_reg;
    s_next.rsp.ack = cfg_req.rd || cfg_req.wr;
    s_next.rsp.rdata = cfg_req.rd ? read_word : 32'h0000_0000;
    if (cfg_req.wr) begin
      if (hit_tenure) begin
        // Header and self-test lanes fall outside the mask and are dropped
        s_next.tenure_line = 16'(merge_write({16'h0000, s_reg.tenure_line}, cfg_req.wdata,
                                             byte_mask, pch_pkg::TENURE_RW_MASK));
      end
      if (hit_base) begin
        s_next.base = merge_write(s_reg.base, cfg_req.wdata, byte_mask,
                                  pch_pkg::BASE_RW_MASK);
      end
      if (hit_pm_second) begin
        s_next.pm_ctrl = merge_write(s_reg.pm_ctrl, cfg_req.wdata, byte_mask,
                                     pch_pkg::PM_CTRL_RW_MASK);
      end
    end
  end

  // All writable fields clear on reset
  always_ff @(posedge clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_reg.rsp <= '0;
      s_reg.tenure_line <= pch_pkg::TENURE_RESET;
      s_reg.base <= pch_pkg::BASE_RESET;
      s_reg.pm_ctrl <= pch_pkg::PM_CTRL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the transfer engines and the window decoder
  assign cfg_rsp = s_reg.rsp;
  assign line_size_setting = s_reg.tenure_line[pch_pkg::LINE_SIZE_LSB +: 8];
  // The decoder must also see the memory response enable, which lives elsewhere
  assign window_base_address = s_reg.base & pch_pkg::BASE_RW_MASK;
  assign power_state = s_reg.pm_ctrl[1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Tenure limit and identity load
  pch_tenure_timer u_tenure (
    .clk(clk),
    .rst_n(rst_n_sync),
    .limit(s_reg.tenure_line[pch_pkg::TENURE_LSB +: 8]),
    .init(init_status),
    .expired(tenure_expired),
    .end_request(tenure_end_request)
  );

  // Identifiers read zero until the load completes
  pch_id_loader u_loader (
    .clk(clk),
    .rst_n(rst_n_sync),
    .ee_sdi(ee_sdi),
    .ee_sclk(ee_sclk),
    .ee_cs(ee_cs),
    .word(board_word),
    .done(board_id_loaded)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n_sync);

  property p_self_test_zero;
    (cfg_req.rd && hit_tenure) |=> cfg_rsp.ack && (cfg_rsp.rdata[31:24] == 8'h00);
  endproperty
  a_self_test_zero: assert property (p_self_test_zero)
    else $error("self-test byte read nonzero");

  property p_header_zero;
    (cfg_req.rd && hit_tenure) |=> (cfg_rsp.rdata[23:16] == 8'h00);
  endproperty
  a_header_zero: assert property (p_header_zero)
    else $error("header layout byte read nonzero");

  property p_base_all_ones;
    (cfg_req.wr && hit_base && cfg_req.be == 4'hF && cfg_req.wdata == 32'hFFFF_FFFF)
      ##1 (cfg_req.rd && hit_base && !cfg_req.wr) |=> (cfg_rsp.rdata == 32'hFFFF_F000);
  endproperty
  a_base_all_ones: assert property (p_base_all_ones)
    else $error("all-ones base write did not read back FFFF F000h");

  property p_base_low_zero;
    (cfg_req.rd && hit_base) |=> (cfg_rsp.rdata[11:0] == 12'h000);
  endproperty
  a_base_low_zero: assert property (p_base_low_zero)
    else $error("base register low bits read nonzero");

  property p_base_pointer_rw;
    (cfg_req.wr && hit_base && cfg_req.be == 4'hF)
      |=> (window_base_address[31:12] == $past(cfg_req.wdata[31:12]));
  endproperty
  a_base_pointer_rw: assert property (p_base_pointer_rw)
    else $error("window base pointer did not take the written value");

  property p_cap_pointer;
    (cfg_req.rd && hit_cap) |=> (cfg_rsp.rdata == 32'h0000_0044);
  endproperty
  a_cap_pointer: assert property (p_cap_pointer)
    else $error("capability pointer did not read 44h");

  property p_line_size_write;
    (cfg_req.wr && hit_tenure && cfg_req.be[0]) |=> (line_size_setting == $past(cfg_req.wdata[7:0]));
  endproperty
  a_line_size_write: assert property (p_line_size_write)
    else $error("line size setting did not take the written byte");

  property p_header_write_ignored;
    (cfg_req.wr && hit_tenure && cfg_req.be == 4'hC) |=> $stable(s_reg.tenure_line);
  endproperty
  a_header_write_ignored: assert property (p_header_write_ignored)
    else $error("write to fixed header bytes changed a register");

  property p_board_before_load;
    (cfg_req.rd && hit_board && !board_id_loaded) |=> (cfg_rsp.rdata == 32'h0000_0000);
  endproperty
  a_board_before_load: assert property (p_board_before_load)
    else $error("board identifier visible before load finished");

  property p_pm_first_word;
    (cfg_req.rd && hit_pm_first) |=> (cfg_rsp.rdata == PM_CAP_WORD);
  endproperty
  a_pm_first_word: assert property (p_pm_first_word)
    else $error("first power management word wrong");

  c_base_sizing: cover property ((cfg_req.wr && hit_base && cfg_req.wdata == 32'hFFFF_FFFF)
    ##1 (cfg_req.rd && hit_base));
  c_board_loaded: cover property ($rose(board_id_loaded));
  c_line_size_set: cover property (cfg_req.wr && hit_tenure && cfg_req.wdata[7:0] != 8'h00);

endmodule : pch_config_regs

// ==== core/pch_id_loader.sv ====
`timescale 1ns/100ps
module pch_id_loader (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ee_sdi,
  output logic ee_sclk,
  output logic ee_cs,
  output logic [31:0] word,
  output logic done
);

  pch_pkg::pch_loader_state_type s_reg;
  pch_pkg::pch_loader_state_type s_next;

  // Shift one identification word in from the serial memory after reset
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.state)
      pch_pkg::LOAD_IDLE: begin
        s_next.state = pch_pkg::LOAD_SHIFT;
        s_next.cs = 1'b1;
        s_next.div = 4'h0;
        s_next.bits = 6'h00;
      end
      pch_pkg::LOAD_SHIFT: begin
        if (s_reg.div == pch_pkg::EE_HALF_CYCLES - 4'h1) begin
          s_next.div = 4'h0;
          s_next.sclk = ~s_reg.sclk;
          if (!s_reg.sclk) begin
            // Sample on the rising edge; the memory moves data on the falling one
            s_next.word = {s_reg.word[30:0], ee_sdi};
            s_next.bits = s_reg.bits + 6'h01;
          end else if (s_reg.bits == pch_pkg::EE_BITS) begin
            s_next.state = pch_pkg::LOAD_DONE;
            s_next.cs = 1'b0;
            s_next.done = 1'b1;
          end
        end else begin
          s_next.div = s_reg.div + 4'h1;
        end
      end
      pch_pkg::LOAD_DONE: begin
        s_next = s_reg;
      end
      default: begin
        s_next.state = pch_pkg::LOAD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ee_sclk = s_reg.sclk;
  assign ee_cs = s_reg.cs;
  assign word = s_reg.word;
  assign done = s_reg.done;

endmodule : pch_id_loader

// ==== core/pch_pkg.sv ====
package pch_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration offsets (byte addresses within the header)
  localparam logic [7:0] OFS_TENURE = 8'h0C;
  localparam logic [7:0] OFS_HEADER = 8'h0E;
  localparam logic [7:0] OFS_BASE = 8'h10;
  localparam logic [7:0] OFS_BOARD_ID = 8'h2C;
  localparam logic [7:0] OFS_CAP_PTR = 8'h34;
  localparam logic [7:0] OFS_PM_FIRST = 8'h44;
  localparam logic [7:0] OFS_PM_SECOND = 8'h48;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions, fixed values and reset values
  localparam int TENURE_LSB = 8;
  localparam int LINE_SIZE_LSB = 0;
  localparam int HEADER_LANE_LSB = 8 * int'(OFS_HEADER[1:0]);
  localparam int BASE_PTR_LSB = 12;
  localparam logic [7:0] SELF_TEST_VALUE = 8'h00;
  localparam logic [7:0] HEADER_LAYOUT_VALUE = 8'h00;
  localparam logic [7:0] CAP_PTR_VALUE = OFS_PM_FIRST;
  localparam logic [15:0] TENURE_RESET = 16'h0000;
  localparam logic [31:0] BASE_RESET = 32'h0000_0000;
  localparam logic [31:0] PM_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] TENURE_RW_MASK = 32'h0000_FFFF;
  localparam logic [31:0] BASE_RW_MASK = 32'hFFFF_F000;
  localparam logic [31:0] PM_CTRL_RW_MASK = 32'h0000_0003;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int EE_HALF_NS = 40;
  localparam logic [3:0] EE_HALF_CYCLES = 4'((EE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] EE_BITS = 6'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers and state
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] dw_addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pch_cfg_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } pch_cfg_rsp_type;

  typedef struct packed {
    logic frame_start;
    logic gnt_n;
    logic done;
  } pch_init_type;

  typedef struct packed {
    logic [7:0] count;
    logic running;
    logic expired;
    logic end_req;
  } pch_tenure_state_type;

  typedef enum logic [1:0] {
    LOAD_IDLE = 2'b00,
    LOAD_SHIFT = 2'b01,
    LOAD_DONE = 2'b10
  } pch_load_state_type;

  typedef struct packed {
    pch_load_state_type state;
    logic [3:0] div;
    logic [5:0] bits;
    logic [31:0] word;
    logic sclk;
    logic cs;
    logic done;
  } pch_loader_state_type;

endpackage : pch_pkg

// ==== core/pch_tenure_timer.sv ====
`timescale 1ns/100ps
module pch_tenure_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] limit,
  input wire pch_pkg::pch_init_type init,
  output logic expired,
  output logic end_request
);

  pch_pkg::pch_tenure_state_type s_reg;
  pch_pkg::pch_tenure_state_type s_next;

  // Count bus ownership from the start of each initiator tenure
  always_comb begin
    s_next = s_reg;
    if (init.frame_start) begin
      s_next.count = 8'h00;
      s_next.running = 1'b1;
    end else if (s_reg.running) begin
      if (init.done) begin
        s_next.running = 1'b0;
      end else if (s_reg.count != 8'hFF) begin
        s_next.count = s_reg.count + 8'h01;
      end
    end
    // A limit of zero expires at once, giving up the bus as soon as grant drops
    s_next.expired = s_next.running && (s_next.count >= limit);
    s_next.end_req = s_reg.expired && s_reg.running && init.gnt_n && !init.done
                     && !init.frame_start;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign expired = s_reg.expired;
  assign end_request = s_reg.end_req;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_tenure_restart;
    @(posedge clk) disable iff (!rst_n)
    init.frame_start |=> (s_reg.count == 8'h00) && s_reg.running;
  endproperty
  a_tenure_restart: assert property (p_tenure_restart)
    else $error("tenure counter did not restart at frame start");

  property p_end_on_grant_loss;
    @(posedge clk) disable iff (!rst_n)
    (expired && init.gnt_n && !init.done && !init.frame_start) |=> end_request;
  endproperty
  a_end_on_grant_loss: assert property (p_end_on_grant_loss)
    else $error("expired tenure did not end after grant loss");

  property p_hold_while_granted;
    @(posedge clk) disable iff (!rst_n)
    !init.gnt_n |=> !end_request;
  endproperty
  a_hold_while_granted: assert property (p_hold_while_granted)
    else $error("transaction ended while grant still held");

  c_tenure_end: cover property (@(posedge clk) disable iff (!rst_n) end_request);

endmodule : pch_tenure_timer

// ==== verification/pch_ee_model.sv ====
`timescale 1ns/100ps
module pch_ee_model #(
  parameter logic [31:0] WORD = 32'h0000_0000 // Arbitrary stored identification word
) (
  input wire logic ee_sclk,
  input wire logic ee_cs,
  output logic ee_sdi
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial identification memory, behavioural
  int idx;

  // Quiet start so the data line is never unknown before the first select
  initial begin
    idx = 31;
    ee_sdi = 1'b0;
  end

  // First bit is presented as soon as the device is selected, MSB first
  always @(posedge ee_cs) begin
    idx = 31;
    ee_sdi = WORD[31];
  end

  // Next bit after each falling clock; past the last bit the line is no longer driven,
  // so the inverse of the last value stands in for a floating wire
  always @(negedge ee_sclk) begin
    if (ee_cs) begin
      idx = idx - 1;
      if (idx >= 0) begin
        ee_sdi = WORD[idx];
      end else begin
        ee_sdi = ~ee_sdi;
      end
    end
  end

  // Deselect releases the line as well
  always @(negedge ee_cs) begin
    ee_sdi = ~ee_sdi;
  end

endmodule : pch_ee_model

// ==== verification/tb_pch_config_regs.sv ====
`timescale 1ns/100ps
module tb_pch_config_regs;

  ////////////////////////////////////////////////////////////////////////////
  // Signals
  localparam logic [31:0] EE_WORD = 32'hA5C3_1E69; // Arbitrary identification value
  logic clk;
  logic nrst;
  pch_pkg::pch_cfg_req_type cfg_req;
  pch_pkg::pch_cfg_rsp_type cfg_rsp;
  pch_pkg::pch_init_type init_status;
  logic [7:0] line_size_setting;
  logic [31:0] window_base_address;
  logic [1:0] power_state;
  logic tenure_expired;
  logic tenure_end_request;
  logic ee_sdi;
  logic ee_sclk;
  logic ee_cs;
  logic board_id_loaded;
  logic [31:0] rdata;
  int err_count;
  int n_compared;
  int i;

  ////////////////////////////////////////////////////////////////////////////
  // Design and its serial identification memory
  pch_config_regs dut (
    .clk(clk),
    .nrst(nrst),
    .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp),
    .init_status(init_status),
    .line_size_setting(line_size_setting),
    .window_base_address(window_base_address),
    .power_state(power_state),
    .tenure_expired(tenure_expired),
    .tenure_end_request(tenure_end_request),
    .ee_sdi(ee_sdi),
    .ee_sclk(ee_sclk),
    .ee_cs(ee_cs),
    .board_id_loaded(board_id_loaded)
  );

  pch_ee_model #(.WORD(EE_WORD)) ee (
    .ee_sclk(ee_sclk),
    .ee_cs(ee_cs),
    .ee_sdi(ee_sdi)
  );

  // 250 MHz clock
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  // One configuration cycle; request held for exactly one taking edge, ack one cycle later
  task access(input logic wr, input logic [7:0] ofs, input logic [3:0] be,
              input logic [31:0] wd);
    @(posedge clk);
    cfg_req <= '{rd: !wr, wr: wr, dw_addr: ofs[7:2], be: be, wdata: wd};
    @(posedge clk);
    cfg_req <= '0;
    #1;
    chk({31'h0, cfg_rsp.ack}, 32'h0000_0001);
    rdata = cfg_rsp.rdata;
  endtask : access

  task rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
    access(1'b0, ofs, 4'h0, 32'h0000_0000);
    chk(rdata, exp);
  endtask : rd_chk

  // Write data answers with zero read data
  task wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] wd);
    access(1'b1, ofs, be, wd);
    chk(rdata, 32'h0000_0000);
  endtask : wr

  // Write then read on consecutive edges, which the bus allows
  task wr_rd(input logic [7:0] ofs, input logic [31:0] wd, input logic [31:0] exp);
    @(posedge clk);
    cfg_req <= '{rd: 1'b0, wr: 1'b1, dw_addr: ofs[7:2], be: 4'hF, wdata: wd};
    @(posedge clk);
    cfg_req <= '{rd: 1'b1, wr: 1'b0, dw_addr: ofs[7:2], be: 4'h0, wdata: 32'h0000_0000};
    #1;
    chk({31'h0, cfg_rsp.ack}, 32'h0000_0001);
    chk(cfg_rsp.rdata, 32'h0000_0000);
    @(posedge clk);
    cfg_req <= '0;
    #1;
    chk({31'h0, cfg_rsp.ack}, 32'h0000_0001);
    chk(cfg_rsp.rdata, exp);
  endtask : wr_rd

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    cfg_req = '0;
    init_status = '0;
    err_count = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    chk(window_base_address, 32'h0000_0000);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, fixed fields and the identification word before its load
    rd_chk(pch_pkg::OFS_TENURE, 32'h0000_0000);
    rd_chk(pch_pkg::OFS_BASE, 32'h0000_0000);
    rd_chk(pch_pkg::OFS_CAP_PTR, 32'h0000_0044);
    rd_chk(pch_pkg::OFS_BOARD_ID, 32'h0000_0000);
    rd_chk(pch_pkg::OFS_PM_FIRST, 32'h0000_0001);
    rd_chk(8'h20, 32'h0000_0000);
    chk({31'h0, ee_cs}, 32'h0000_0001);
    // Tenure and line size: upper half is header layout and self-test, always zero
    wr(pch_pkg::OFS_TENURE, 4'hF, 32'hFFFF_FFFF);
    rd_chk(pch_pkg::OFS_TENURE, 32'h0000_FFFF);
    chk({24'h0, line_size_setting}, 32'h0000_00FF);
    wr(pch_pkg::OFS_TENURE, 4'h1, 32'hFFFF_FF5A);
    wr(pch_pkg::OFS_TENURE, 4'h2, 32'h0000_0200);
    rd_chk(pch_pkg::OFS_TENURE, 32'h0000_025A);
    chk({24'h0, line_size_setting}, 32'h0000_005A);
    // A write that reaches only the fixed header lanes must leave the register alone
    wr(pch_pkg::OFS_TENURE, 4'hC, 32'hFFFF_FFFF);
    rd_chk(pch_pkg::OFS_TENURE, 32'h0000_025A);
    // Base address: back-to-back sizing, then a real placement with a lane-wise update
    wr_rd(pch_pkg::OFS_BASE, 32'hFFFF_FFFF, 32'hFFFF_F000);
    chk(window_base_address, 32'hFFFF_F000);
    wr(pch_pkg::OFS_BASE, 4'hF, 32'h1234_5FFF);
    rd_chk(pch_pkg::OFS_BASE, 32'h1234_5000);
    wr(pch_pkg::OFS_BASE, 4'h8, 32'hAB00_0FFF);
    rd_chk(pch_pkg::OFS_BASE, 32'hAB34_5000);
    wr(pch_pkg::OFS_BASE, 4'h1, 32'h0000_000F);
    rd_chk(pch_pkg::OFS_BASE, 32'hAB34_5000);
    // Standing in for software, the bench never enters the window, only its base
    chk(window_base_address, 32'hAB34_5000);
    // Read-only places keep their values after writes; the power management control word takes only its two writable bits
    wr(pch_pkg::OFS_CAP_PTR, 4'hF, 32'hFFFF_FFFF);
    rd_chk(pch_pkg::OFS_CAP_PTR, 32'h0000_0044);
    wr(pch_pkg::OFS_PM_FIRST, 4'hF, 32'hFFFF_FFFF);
    rd_chk(pch_pkg::OFS_PM_FIRST, 32'h0000_0001);
    wr(pch_pkg::OFS_PM_SECOND, 4'hF, 32'hFFFF_FFFF);
    rd_chk(pch_pkg::OFS_PM_SECOND, 32'h0000_0003);
    chk({30'h0, power_state}, 32'h0000_0003);
    // Identification load, bounded wait
    for (i = 0; i < 2000 && board_id_loaded !== 1'b1; i++) begin
      @(posedge clk);
    end
    if (board_id_loaded !== 1'b1) begin
      $display("BAD at %0t: got %h expected %h", $time, board_id_loaded, 1'b1);
      err_count++;
      end_sim();
    end
    chk({31'h0, ee_cs}, 32'h0000_0000);
    rd_chk(pch_pkg::OFS_BOARD_ID, EE_WORD);
    wr(pch_pkg::OFS_BOARD_ID, 4'hF, ~EE_WORD);
    rd_chk(pch_pkg::OFS_BOARD_ID, EE_WORD);
    // Tenure: limit is 2, grant held so no end request until it is withdrawn
    @(posedge clk);
    init_status <= '{frame_start: 1'b1, gnt_n: 1'b0, done: 1'b0};
    @(posedge clk);
    init_status.frame_start <= 1'b0;
    #1;
    chk({31'h0, tenure_expired}, 32'h0000_0000);
    @(posedge clk);
    #1;
    chk({31'h0, tenure_expired}, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, tenure_expired}, 32'h0000_0001);
    chk({31'h0, tenure_end_request}, 32'h0000_0000);
    @(posedge clk);
    init_status.gnt_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, tenure_end_request}, 32'h0000_0001);
    @(posedge clk);
    init_status.done <= 1'b1;
    @(posedge clk);
    init_status.done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, tenure_end_request}, 32'h0000_0000);
    chk({31'h0, tenure_expired}, 32'h0000_0000);
    // New tenure restarts from zero even with the grant withdrawn
    @(posedge clk);
    init_status.frame_start <= 1'b1;
    @(posedge clk);
    init_status.frame_start <= 1'b0;
    @(posedge clk);
    #1;
    chk({31'h0, tenure_expired}, 32'h0000_0000);
    chk({31'h0, tenure_end_request}, 32'h0000_0000);
    @(posedge clk);
    init_status.done <= 1'b1;
    @(posedge clk);
    init_status.done <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, tenure_expired}, 32'h0000_0000);
    // Reset in mid-run: writable fields clear and identifiers hide until reloaded
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(pch_pkg::OFS_TENURE, 32'h0000_0000);
    rd_chk(pch_pkg::OFS_BASE, 32'h0000_0000);
    rd_chk(pch_pkg::OFS_PM_SECOND, 32'h0000_0000);
    rd_chk(pch_pkg::OFS_BOARD_ID, 32'h0000_0000);
    chk({24'h0, line_size_setting}, 32'h0000_0000);
    chk(window_base_address, 32'h0000_0000);
    end_sim();
  end

endmodule : tb_pch_config_regs
